/* File: rtl/ccad_alu.sv */
// adder with status flags and unsigned 8x8 multiplier
`timescale 1ns/100ps
`default_nettype none
module ccad_alu
	import ccad_pkg::*;
(
	input  wire logic [7:0]  a_i,
	input  wire logic [7:0]  b_i,
	output logic      [7:0]  sum_o,
	output logic      [4:0]  flags_o,
	output logic      [15:0] prod_o
);
	logic [8:0] full;
	logic [4:0] low;

	always_comb
	begin
		full = 9'(a_i) + 9'(b_i);
		low = 5'(a_i[3:0]) + 5'(b_i[3:0]);
		sum_o = full[7:0];
		flags_o = '0;
		flags_o[`CCAD_ST_C] = full[8];
		flags_o[`CCAD_ST_DC] = low[4];
		flags_o[`CCAD_ST_Z] = (full[7:0] == 8'h00);
		flags_o[`CCAD_ST_N] = full[7];
		// signed overflow: like signs in, other sign out
		flags_o[`CCAD_ST_OV] = (a_i[7] == b_i[7]) && (full[7] != a_i[7]);
		prod_o = 16'(a_i) * 16'(b_i);
	end
endmodule
`default_nettype wire

/* File: rtl/ccad_decoder_core.sv */
// decoder and execute control for branch, call, return, add and multiply
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - conditional branches on flags, one or two cycles
// - taken or pc-changing ops add a nop cycle
// - absolute call and jump take two words; relative call and jump take one
// - stray second word executes as nop
// - zero word and 1111 prefix are nops
// - standby and watchdog clear set timeout; standby clears powerdown, watchdog clear sets it
// - push and pop return stack, no flags
// - interrupt return sets enable; either return with bit 0 set restores shadows
// - literal return loads working register, two cycles
// - port operand comes from pins, not latch
// - writing timer zero clears assigned prescaler
// - add literal updates working register and flags
// - add to file, d picks destination
// - a bit picks access bank or bank select
// - literal multiply fills product high and low
// - file multiply leaves both operands unchanged
module ccad_decoder_core
	import ccad_pkg::*;
#(
	parameter logic [11:0] PORT_ADDR       = 12'h0F00,
	parameter logic [11:0] TIMER_ZERO_ADDR = 12'h0F10
)
(
	input  wire logic                  clock_i,
	input  wire logic                  reset_i,
	input  wire logic [15:0]           instr_i,
	input  wire logic                  instr_valid_i,
	output logic                       instr_ready_o,
	output logic [`CCAD_PC_W-1:0]      pc_o,
	output logic [11:0]                file_addr_o,
	output logic                       file_rd_o,
	input  wire logic [7:0]            file_rdata_i,
	output logic                       file_we_o,
	output logic [7:0]                 file_wdata_o,
	input  wire logic [7:0]            port_pins_i,
	input  wire logic                  prescaler_assigned_i,
	output logic                       prescaler_clear_o,
	output logic                       watchdog_clear_o,
	output logic                       standby_o,
	output logic                       gie_o,
	input  wire logic [`CCAD_REG_AW-1:0] reg_addr_i,
	input  wire logic [7:0]            reg_wdata_i,
	input  wire logic                  reg_wr_i,
	input  wire logic                  reg_rd_i,
	output logic [7:0]                 reg_rdata_o
);
	// ==========================================================
	// state
	localparam ccad_core_s CORE_RST = '{
		state:     ST_EXEC,
		pc:        `CCAD_RST_PC,
		timeout:   `CCAD_RST_TO,
		powerdown: `CCAD_RST_PD,
		ready:     1'b1,
		default:   '0
	};

	ccad_core_s                q;
	ccad_core_s                n;
	logic                      take;
	logic                      exec_take;
	logic [7:0]                alu_b;
	logic [7:0]                operand;
	logic [7:0]                alu_sum;
	logic [4:0]                alu_flags;
	logic [15:0]               alu_prod;
	logic                      st_we;
	logic [`CCAD_PC_W-1:0]     st_wdata;
	logic [`CCAD_PC_W-1:0]     st_rdata;
	logic [`CCAD_SP_W-1:0]     st_raddr;

	// ==========================================================
	// helpers
	function automatic logic cond_met(input logic [2:0] c,
		input logic [4:0] s);
		logic f;
		unique case (c[2:1])
			2'b00: f = s[`CCAD_ST_Z];
			2'b01: f = s[`CCAD_ST_C];
			2'b10: f = s[`CCAD_ST_OV];
			2'b11: f = s[`CCAD_ST_N];
		endcase
		return f ^ c[0];
	endfunction

	function automatic logic [11:0] bank_addr(input logic a,
		input logic [7:0] f, input logic [3:0] bank_select_register);
		if (a)
			return {bank_select_register, f};
		// access bank: low half from bank 0, high half from the top bank
		if (f < `CCAD_ACCESS_SPLIT)
			return {4'h0, f};
		return {`CCAD_ACCESS_HI, f};
	endfunction

	assign take = instr_valid_i && q.ready;
	assign exec_take = take && (q.state == ST_EXEC);
	// port reads see the synchronised pin levels, not the output latch
	assign operand = (q.file_addr == PORT_ADDR) ? q.pins : file_rdata_i;
	assign alu_b = (q.state == ST_FILE) ? operand : instr_i[7:0];
	assign st_raddr = `CCAD_SP_W'(q.sp - 4'h1);

	ccad_alu u_alu (
		.a_i     (q.working_register),
		.b_i     (alu_b),
		.sum_o   (alu_sum),
		.flags_o (alu_flags),
		.prod_o  (alu_prod)
	);

	ccad_stack_mem #(
		.AW (`CCAD_SP_W),
		.DW (`CCAD_PC_W)
	) u_stack (
		.clock_i (clock_i),
		.we_i    (st_we),
		.waddr_i (q.sp),
		.wdata_i (st_wdata),
		.raddr_i (st_raddr),
		.rdata_o (st_rdata)
	);

	// ==========================================================
	// next state
	always_comb
	begin
		n = q;
		st_we = 1'b0;
		st_wdata = q.pc + `CCAD_PC_STEP;
		n.file_rd = 1'b0;
		n.file_we = 1'b0;
		n.presc_clr = 1'b0;
		n.wdt_clr = 1'b0;
		n.standby = 1'b0;
		n.sync1 = port_pins_i;
		n.sync2 = q.sync1;
		n.sync3 = q.sync2;
		if (q.sync2 == q.sync3)
			n.pins = q.sync3;
		unique case (q.state)
			ST_EXEC:
			if (take)
			begin
				n.pc = q.pc + `CCAD_PC_STEP;
				if (instr_i[15:12] == 4'hF || instr_i == 16'h0000)
					n.state = ST_EXEC;
				else if (instr_i[15:11] == 5'b11100)
				begin
					if (cond_met(instr_i[10:8], q.status))
					begin
						n.pc = q.pc + `CCAD_PC_STEP
							+ {{12{instr_i[7]}}, instr_i[7:0], 1'b0};
						n.state = ST_FLUSH;
					end
				end
				else if (instr_i[15:12] == 4'hD)
				begin
					// relative jump, or relative call when bit 11 is set
					st_we = instr_i[11];
					n.sp = instr_i[11] ? `CCAD_SP_W'(q.sp + 4'h1) : q.sp;
					n.pc = q.pc + `CCAD_PC_STEP
						+ {{9{instr_i[10]}}, instr_i[10:0], 1'b0};
					n.state = ST_FLUSH;
				end
				else if (instr_i[15:9] == 7'b1110110 || instr_i[15:8] == 8'hEF)
				begin
					n.call_push = (instr_i[11:9] == 3'b110);
					n.call_shadow = instr_i[8];
					n.call_low = instr_i[7:0];
					n.state = ST_SECOND;
				end
				else if (instr_i == 16'h0003)
				begin
					n.timeout = 1'b1;
					n.powerdown = 1'b0;
					n.standby = 1'b1;
				end
				else if (instr_i == 16'h0004)
				begin
					n.timeout = 1'b1;
					n.powerdown = 1'b1;
					n.wdt_clr = 1'b1;
				end
				else if (instr_i == 16'h0005)
				begin
					st_we = 1'b1;
					n.sp = `CCAD_SP_W'(q.sp + 4'h1);
				end
				else if (instr_i == 16'h0006)
					n.sp = st_raddr;
				else if (instr_i[15:2] == 14'h0004)
				begin
					// bit 1 clear: interrupt return, set: plain return
					if (!instr_i[1])
						n.gie = 1'b1;
					if (instr_i[0])
					begin
						n.working_register = q.ws;
						n.status = q.statuss;
						n.bank_select_register = q.bsrs;
					end
					n.ret_pend = 1'b1;
					n.state = ST_FLUSH;
				end
				else if (instr_i[15:8] == 8'h0C)
				begin
					n.working_register = instr_i[7:0];
					n.ret_pend = 1'b1;
					n.state = ST_FLUSH;
				end
				else if (instr_i[15:8] == 8'h0F)
				begin
					n.working_register = alu_sum;
					n.status = alu_flags;
				end
				else if (instr_i[15:8] == 8'h0D)
					{n.product_high, n.product_low} = alu_prod;
				else if (instr_i[15:10] == 6'b001001
					|| instr_i[15:9] == 7'b0000001)
				begin
					n.file_op = instr_i[13];
					n.file_d = instr_i[9];
					n.file_addr = bank_addr(instr_i[8], instr_i[7:0], q.bank_select_register);
					n.file_rd = 1'b1;
					n.ready = 1'b0;
					n.state = ST_FILE;
				end
			end
			ST_SECOND:
			if (take)
			begin
				n.pc = {instr_i[11:0], q.call_low, 1'b0};
				if (q.call_push)
				begin
					st_we = 1'b1;
					n.sp = `CCAD_SP_W'(q.sp + 4'h1);
					if (q.call_shadow)
					begin
						n.ws = q.working_register;
						n.statuss = q.status;
						n.bsrs = q.bank_select_register;
					end
				end
				n.state = ST_FLUSH;
			end
			ST_FLUSH:
			if (take)
			begin
				// the offered word is dropped; pc holds the target, or takes it from the stack on a return
				n.state = ST_EXEC;
				if (q.ret_pend)
				begin
					n.pc = st_rdata;
					n.sp = st_raddr;
					n.ret_pend = 1'b0;
				end
			end
			ST_FILE:
			begin
				n.state = ST_EXEC;
				n.ready = 1'b1;
				if (q.file_op)
				begin
					n.status = alu_flags;
					if (q.file_d)
					begin
						n.file_we = 1'b1;
						n.file_wdata = alu_sum;
						n.presc_clr = (q.file_addr == TIMER_ZERO_ADDR)
							&& prescaler_assigned_i;
					end
					else
						n.working_register = alu_sum;
				end
				else
					{n.product_high, n.product_low} = alu_prod;
			end
		endcase
		// software writes land after the instruction, so software wins
		if (reg_wr_i)
		begin
			unique case (reg_addr_i)
				`CCAD_OFF_WORKING_REGISTER:   n.working_register = reg_wdata_i;
				`CCAD_OFF_STATUS: n.status = reg_wdata_i[4:0];
				`CCAD_OFF_BSR:    n.bank_select_register = reg_wdata_i[3:0];
				`CCAD_OFF_PRODUCT_LOW:  n.product_low = reg_wdata_i;
				`CCAD_OFF_PRODUCT_HIGH:  n.product_high = reg_wdata_i;
				`CCAD_OFF_CTRL:
				begin
					n.gie = reg_wdata_i[`CCAD_CTL_GIE];
					n.timeout = reg_wdata_i[`CCAD_CTL_TO];
					n.powerdown = reg_wdata_i[`CCAD_CTL_PD];
				end
				default: n.working_register = n.working_register;
			endcase
		end
		n.rdata = `CCAD_RST_BYTE;
		if (reg_rd_i)
		begin
			unique case (reg_addr_i)
				`CCAD_OFF_WORKING_REGISTER:   n.rdata = q.working_register;
				`CCAD_OFF_STATUS: n.rdata = {3'h0, q.status};
				`CCAD_OFF_BSR:    n.rdata = {4'h0, q.bank_select_register};
				`CCAD_OFF_PRODUCT_LOW:  n.rdata = q.product_low;
				`CCAD_OFF_PRODUCT_HIGH:  n.rdata = q.product_high;
				`CCAD_OFF_CTRL:   n.rdata = {5'h00, q.powerdown, q.timeout, q.gie};
				`CCAD_OFF_SP:     n.rdata = 8'(q.sp);
				`CCAD_OFF_PCL:    n.rdata = q.pc[7:0];
				default:          n.rdata = `CCAD_RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge clock_i)
		q <= reset_i ? CORE_RST : n;

	// ==========================================================
	// outputs
	assign instr_ready_o = q.ready;
	assign pc_o = q.pc;
	assign file_addr_o = q.file_addr;
	assign file_rd_o = q.file_rd;
	assign file_we_o = q.file_we;
	assign file_wdata_o = q.file_wdata;
	assign prescaler_clear_o = q.presc_clr;
	assign watchdog_clear_o = q.wdt_clr;
	assign standby_o = q.standby;
	assign gie_o = q.gie;
	assign reg_rdata_o = q.rdata;

	// ==========================================================
	// checks
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (reset_i);

	chk_branch_taken: assert property (
		exec_take && instr_i[15:11] == 5'b11100 && cond_met(instr_i[10:8], q.status)
		|=> q.state == ST_FLUSH ##1 (q.state == ST_FLUSH || q.state == ST_EXEC))
		else $error("taken branch did not flush");
	chk_branch_skip: assert property (
		exec_take && instr_i[15:11] == 5'b11100 && !cond_met(instr_i[10:8], q.status)
		|=> q.state == ST_EXEC && q.pc == $past(q.pc) + `CCAD_PC_STEP)
		else $error("untaken branch not single cycle");
	chk_flush_nop: assert property (
		q.state == ST_FLUSH && take && !q.ret_pend && !reg_wr_i
		|=> q.pc == $past(q.pc) && $stable(q.working_register) && q.state == ST_EXEC)
		else $error("second cycle was not a no-operation");
	chk_call_target: assert property (
		q.state == ST_SECOND && take
		|=> q.state == ST_FLUSH && q.pc[8:1] == $past(q.call_low))
		else $error("two-word target wrong");
	chk_nop_word: assert property (
		exec_take && instr_i[15:12] == 4'hF && !reg_wr_i
		|=> $stable(q.status) && q.state == ST_EXEC)
		else $error("no-operation word changed state");
	chk_sleep_flags: assert property (
		exec_take && instr_i == 16'h0003 && !reg_wr_i
		|=> standby_o && q.timeout && !q.powerdown)
		else $error("standby flags wrong");
	chk_push_depth: assert property (
		exec_take && instr_i == 16'h0005
		|=> q.sp == `CCAD_SP_W'($past(q.sp) + 4'h1) && q.state == ST_EXEC)
		else $error("push did not grow stack");
	chk_interrupt_return_op_gie: assert property (
		exec_take && instr_i[15:1] == 15'h0008 && !reg_wr_i
		|=> gie_o && q.ret_pend && q.state == ST_FLUSH)
		else $error("interrupt return did not enable");
	chk_literal_return_op_value: assert property (
		exec_take && instr_i[15:8] == 8'h0C && !reg_wr_i
		|=> q.working_register == $past(instr_i[7:0]) && $stable(q.status))
		else $error("literal return value wrong");
	chk_presc_clear: assert property (
		prescaler_clear_o |-> file_we_o && file_addr_o == TIMER_ZERO_ADDR)
		else $error("prescaler cleared without timer write");
	chk_add_literal_op_sum: assert property (
		exec_take && instr_i[15:8] == 8'h0F && !reg_wr_i
		|=> q.working_register == 8'($past(q.working_register) + $past(instr_i[7:0]))
		&& q.status[`CCAD_ST_Z] == (q.working_register == 8'h00)
		&& q.status[`CCAD_ST_N] == q.working_register[7])
		else $error("add literal result or flags wrong");
	chk_file_write: assert property (
		exec_take && instr_i[15:9] == 7'b0010011 && !instr_i[8] && !instr_i[7]
		|=> q.state == ST_FILE && file_addr_o[11:8] == 4'h0 ##1 file_we_o)
		else $error("add to file write-back missing");
	chk_multiply_literal_op_prod: assert property (
		exec_take && instr_i[15:8] == 8'h0D && !reg_wr_i
		|=> {q.product_high, q.product_low}
		== 16'($past(q.working_register)) * 16'($past(instr_i[7:0])))
		else $error("literal product wrong");
	chk_multiply_file_op_keep: assert property (
		q.state == ST_FILE && !q.file_op && !reg_wr_i
		|=> $stable(q.working_register) && !file_we_o)
		else $error("file multiply disturbed operands");

	cov_branch_taken: cover property (
		exec_take && instr_i[15:11] == 5'b11100 ##1 q.state == ST_FLUSH);
	cov_call_return: cover property (
		q.state == ST_SECOND && take && q.call_push);
	cov_port_add: cover property (
		q.state == ST_FILE && q.file_op && q.file_addr == PORT_ADDR);
endmodule
`default_nettype wire

/* File: rtl/ccad_defs.svh */
// constants of the control and arithmetic decoder: offsets, fields, resets
`ifndef CCAD_DEFS_SVH
`define CCAD_DEFS_SVH

// ==========================================================
// widths
`define CCAD_PC_W         21
`define CCAD_SP_W         4
`define CCAD_REG_AW       4

// ==========================================================
// register offsets on the plain software port
`define CCAD_OFF_WORKING_REGISTER     4'h0
`define CCAD_OFF_STATUS   4'h1
`define CCAD_OFF_BSR      4'h2
`define CCAD_OFF_PRODUCT_LOW    4'h3
`define CCAD_OFF_PRODUCT_HIGH    4'h4
`define CCAD_OFF_CTRL     4'h5
`define CCAD_OFF_SP       4'h6
`define CCAD_OFF_PCL      4'h7

// ==========================================================
// field positions
`define CCAD_ST_C         0
`define CCAD_ST_DC        1
`define CCAD_ST_Z         2
`define CCAD_ST_OV        3
`define CCAD_ST_N         4
`define CCAD_CTL_GIE      0
`define CCAD_CTL_TO       1
`define CCAD_CTL_PD       2

// ==========================================================
// reset values and steps
`define CCAD_RST_PC       21'h0_0000
`define CCAD_RST_BYTE     8'h00
`define CCAD_RST_TO       1'b1
`define CCAD_RST_PD       1'b1
`define CCAD_PC_STEP      21'h0_0002
`define CCAD_ACCESS_SPLIT 8'h80
`define CCAD_ACCESS_HI    4'hF

`endif

/* File: rtl/ccad_pkg.sv */
// types shared by the control and arithmetic decoder
package ccad_pkg;
`include "ccad_defs.svh"

	typedef enum logic [1:0] {
		ST_EXEC   = 2'b00,
		ST_SECOND = 2'b01,
		ST_FLUSH  = 2'b10,
		ST_FILE   = 2'b11
	} ccad_state_e;

	typedef struct packed {
		ccad_state_e                state;
		logic [`CCAD_PC_W-1:0]      pc;
		logic [`CCAD_SP_W-1:0]      sp;
		logic [7:0]                 working_register;
		logic [4:0]                 status;
		logic [3:0]                 bank_select_register;
		logic [7:0]                 product_low;
		logic [7:0]                 product_high;
		logic                       gie;
		logic                       timeout;
		logic                       powerdown;
		logic [7:0]                 ws;
		logic [4:0]                 statuss;
		logic [3:0]                 bsrs;
		logic                       ret_pend;
		logic                       call_push;
		logic                       call_shadow;
		logic [7:0]                 call_low;
		logic                       file_op;
		logic                       file_d;
		logic [11:0]                file_addr;
		logic                       file_rd;
		logic                       file_we;
		logic [7:0]                 file_wdata;
		logic                       presc_clr;
		logic                       wdt_clr;
		logic                       standby;
		logic                       ready;
		logic [7:0]                 rdata;
		logic [7:0]                 sync1;
		logic [7:0]                 sync2;
		logic [7:0]                 sync3;
		logic [7:0]                 pins;
	} ccad_core_s;

endpackage

/* File: rtl/ccad_stack_mem.sv */
// return stack storage with registered read data
`timescale 1ns/100ps
`default_nettype none
module ccad_stack_mem
	import ccad_pkg::*;
#(
	parameter int AW = 4,
	parameter int DW = 21
)
(
	input  wire logic          clock_i,
	input  wire logic          we_i,
	input  wire logic [AW-1:0] waddr_i,
	input  wire logic [DW-1:0] wdata_i,
	input  wire logic [AW-1:0] raddr_i,
	output logic      [DW-1:0] rdata_o
);
	typedef struct packed {
		logic [(1<<AW)-1:0][DW-1:0] mem;
		logic [DW-1:0]              rdata;
	} ccad_stk_s;

	ccad_stk_s q;
	ccad_stk_s n;

	always_comb
	begin
		n = q;
		if (we_i)
			n.mem[waddr_i] = wdata_i;
		n.rdata = q.mem[raddr_i];
	end

	always_ff @(posedge clock_i)
		q <= n;

	assign rdata_o = q.rdata;
endmodule
`default_nettype wire

/* File: tb/ccad_prog_mem.sv */
// program memory model offering words at the decoder's pc
`timescale 1ns/100ps
`default_nettype none
module ccad_prog_mem
(
	input  wire logic        clock_i,
	input  wire logic        enable_i,
	input  wire logic        slow_i,
	input  wire logic [20:0] pc_i,
	output logic      [15:0] instr_o,
	output logic             valid_o
);
	logic [15:0] mem [0:63];
	logic [1:0]  phase_ff = 2'h0;

	// ==========================================================
	// offer
	// slow mode offers one cycle in four to stress the handshake
	always_ff @(posedge clock_i)
	begin
		phase_ff <= phase_ff + 2'h1;
	end

	assign valid_o = enable_i && !(slow_i && phase_ff != 2'h0);
	// every location holds a word, a stray second word too
	// a word not offered shows its inverse, never a stale copy
	assign instr_o = valid_o ? mem[pc_i[6:1]] : ~mem[pc_i[6:1]];
endmodule
`default_nettype wire

/* File: tb/tb_ccad_decoder_core.sv */
// self-checking bench: reset values, software port, four programs
`timescale 1ns/100ps
`default_nettype none
`include "ccad_defs.svh"
module tb_ccad_decoder_core
	import ccad_pkg::*;
;
	logic        clock_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        enable = 1'b0;
	logic        slow = 1'b0;
	logic        presc_asg = 1'b1;
	logic [7:0]  pins = 8'h00;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	logic [3:0]  reg_addr_i = 4'h0;
	logic [7:0]  reg_wdata_i = 8'h00;
	logic [15:0] instr;
	logic        valid;
	logic        ready;
	logic [20:0] pc_o;
	logic [11:0] file_addr_o;
	logic        file_rd;
	logic        file_we_o;
	logic [7:0]  file_wdata_o;
	logic        prescaler_clear_o;
	logic        watchdog_clear_o;
	logic        standby_o;
	logic        gie_o;
	logic [7:0]  reg_rdata_o;
	logic [7:0]  fmem [0:4095];
	int          miscompares = 0;
	int          num_checks = 0;
	int          n_presc;
	int          n_wdt;
	int          n_stby;
	int          n_frd;

	always #4 clock_i = ~clock_i;

	ccad_prog_mem i_mem (.clock_i(clock_i), .enable_i(enable),
		.slow_i(slow), .pc_i(pc_o), .instr_o(instr), .valid_o(valid));

	ccad_decoder_core i_dut (.clock_i(clock_i), .reset_i(reset_i),
		.instr_i(instr), .instr_valid_i(valid), .instr_ready_o(ready),
		.pc_o(pc_o), .file_addr_o(file_addr_o), .file_rd_o(file_rd),
		.file_rdata_i(fmem[file_addr_o]), .file_we_o(file_we_o),
		.file_wdata_o(file_wdata_o), .port_pins_i(pins),
		.prescaler_assigned_i(presc_asg),
		.prescaler_clear_o(prescaler_clear_o),
		.watchdog_clear_o(watchdog_clear_o), .standby_o(standby_o),
		.gie_o(gie_o), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));

	// ==========================================================
	// file register model and pulse counters
	always @(posedge clock_i)
	begin
		if (file_we_o === 1'b1)
			fmem[file_addr_o] <= file_wdata_o;
		if (reset_i)
		begin
			n_presc <= 0;
			n_wdt <= 0;
			n_stby <= 0;
			n_frd <= 0;
		end
		else
		begin
			n_presc <= n_presc + int'(prescaler_clear_o);
			n_wdt <= n_wdt + int'(watchdog_clear_o);
			n_stby <= n_stby + int'(standby_o);
			// a file access is a read pulse inside the stall cycle
			n_frd <= n_frd + int'(file_rd && !ready);
		end
	end

	// ==========================================================
	// tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clock_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clock_i);
		reg_rd_i <= 1'b0;
		#1;
		check(reg_rdata_o, exp);
	endtask

	task automatic restart(input logic s);
		@(posedge clock_i);
		reset_i <= 1'b1;
		enable <= 1'b0;
		slow <= s;
		repeat (10) @(posedge clock_i);
		reset_i <= 1'b0;
		for (int i = 0; i < 64; i++)
			i_mem.mem[i] = 16'h0000;
	endtask

	// runs until the program reaches its closing self-loop
	task automatic run_to(input logic [20:0] a);
		int n;
		n = 0;
		@(posedge clock_i);
		enable <= 1'b1;
		do
		begin
			@(posedge clock_i);
			#1;
			n++;
		end
		while (pc_o !== a && n < 1000);
		check(8'(n >= 1000), 8'h00);
		repeat (20) @(posedge clock_i);
	endtask

	task automatic stop_test();
		if (miscompares == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ==========================================================
	// tests
	initial
	begin
		restart(1'b0);
		reg_rd(`CCAD_OFF_WORKING_REGISTER, `CCAD_RST_BYTE);
		reg_rd(`CCAD_OFF_STATUS, `CCAD_RST_BYTE);
		reg_rd(`CCAD_OFF_BSR, `CCAD_RST_BYTE);
		reg_rd(`CCAD_OFF_PRODUCT_LOW, `CCAD_RST_BYTE);
		reg_rd(`CCAD_OFF_PRODUCT_HIGH, `CCAD_RST_BYTE);
		reg_rd(`CCAD_OFF_CTRL, {5'h00, `CCAD_RST_PD, `CCAD_RST_TO, 1'b0});
		reg_rd(`CCAD_OFF_PCL, 8'h00);
		reg_wr(`CCAD_OFF_WORKING_REGISTER, 8'h5A);
		reg_rd(`CCAD_OFF_WORKING_REGISTER, 8'h5A);
		reg_wr(`CCAD_OFF_SP, 8'h05);
		reg_rd(`CCAD_OFF_SP, 8'h00);
		reg_rd(4'hE, 8'h00);

		// flags, multiply, then every branch condition on 0x0D flags
		restart(1'b0);
		i_mem.mem[0] = 16'h0F7F;
		i_mem.mem[1] = 16'h0F01;
		i_mem.mem[2] = 16'h0DE2;
		i_mem.mem[3] = 16'h0F80;
		for (int c = 0; c < 8; c++)
		begin
			i_mem.mem[4 + 2 * c] = 16'hE001 | 16'(c << 8);
			i_mem.mem[5 + 2 * c] = 16'h0005;
		end
		i_mem.mem[20] = 16'hD7FF;
		run_to(21'h00_0028);
		reg_rd(`CCAD_OFF_WORKING_REGISTER, 8'h00);
		reg_rd(`CCAD_OFF_STATUS, 8'h0D);
		reg_rd(`CCAD_OFF_PRODUCT_HIGH, 8'h71);
		reg_rd(`CCAD_OFF_PRODUCT_LOW, 8'h00);
		reg_rd(`CCAD_OFF_SP, 8'h04);

		// file operations, banks, port pins and timer zero
		restart(1'b0);
		fmem[12'h020] = 8'hC2;
		fmem[12'hF30] = 8'h05;
		fmem[12'hF10] = 8'h33;
		fmem[12'hF00] = 8'hAA;
		i_mem.mem[0] = 16'h0F17;
		i_mem.mem[1] = 16'h2620;
		i_mem.mem[2] = 16'h2530;
		i_mem.mem[3] = 16'h0330;
		i_mem.mem[4] = 16'h2710;
		i_mem.mem[5] = 16'h2700;
		i_mem.mem[6] = 16'hD7FF;
		pins <= 8'h40;
		reg_wr(`CCAD_OFF_BSR, 8'h0F);
		run_to(21'h00_000C);
		check(fmem[12'h020], 8'hD9);
		check(fmem[12'hF30], 8'h05);
		check(fmem[12'hF10], 8'h4F);
		check(fmem[12'hF00], 8'h5C);
		check(8'(n_presc), 8'h01);
		check(8'(n_frd), 8'h05);
		reg_rd(`CCAD_OFF_WORKING_REGISTER, 8'h1C);
		reg_rd(`CCAD_OFF_PRODUCT_LOW, 8'h8C);
		reg_rd(`CCAD_OFF_PRODUCT_HIGH, 8'h00);
		reg_rd(`CCAD_OFF_STATUS, 8'h00);

		// calls, returns, branches and no-ops, prompt and stalling
		for (int s = 0; s < 2; s++)
		begin
			restart(s[0]);
			i_mem.mem[0] = 16'hEC10;
			i_mem.mem[1] = 16'hF000;
			i_mem.mem[2] = 16'h0F01;
			i_mem.mem[3] = 16'hE001;
			i_mem.mem[4] = 16'hE601;
			i_mem.mem[5] = 16'h0F40;
			i_mem.mem[6] = 16'hF123;
			i_mem.mem[8] = 16'hEC12;
			i_mem.mem[9] = 16'hF000;
			i_mem.mem[10] = 16'h0005;
			i_mem.mem[11] = 16'h0006;
			i_mem.mem[12] = 16'h0004;
			i_mem.mem[13] = 16'h0003;
			i_mem.mem[14] = 16'hD7FF;
			i_mem.mem[16] = 16'h0C80;
			i_mem.mem[18] = 16'h0F04;
			i_mem.mem[19] = 16'h0010;
			run_to(21'h00_001C);
			reg_rd(`CCAD_OFF_WORKING_REGISTER, 8'h85);
			reg_rd(`CCAD_OFF_STATUS, 8'h10);
			reg_rd(`CCAD_OFF_CTRL, 8'h03);
			reg_rd(`CCAD_OFF_SP, 8'h00);
			check({7'h00, gie_o}, 8'h01);
			check(8'(n_wdt), 8'h01);
			check(8'(n_stby), 8'h01);
		end

		// shadowed call, relative call, jump, plain returns with and without shadows, free prescaler
		restart(1'b0);
		fmem[12'hF10] = 8'h00;
		i_mem.mem[0] = 16'h0F33;
		i_mem.mem[1] = 16'hED08;
		i_mem.mem[2] = 16'hF000;
		i_mem.mem[3] = 16'hD806;
		i_mem.mem[4] = 16'hEF0C;
		i_mem.mem[5] = 16'hF000;
		i_mem.mem[8] = 16'h0F01;
		i_mem.mem[9] = 16'h0013;
		i_mem.mem[10] = 16'h0F02;
		i_mem.mem[11] = 16'h0012;
		i_mem.mem[12] = 16'h2710;
		i_mem.mem[13] = 16'hD7FF;
		presc_asg <= 1'b0;
		reg_wr(`CCAD_OFF_BSR, 8'h0F);
		run_to(21'h00_001A);
		check(fmem[12'hF10], 8'h35);
		check(8'(n_presc), 8'h00);
		check({7'h00, gie_o}, 8'h00);
		reg_rd(`CCAD_OFF_WORKING_REGISTER, 8'h35);
		reg_rd(`CCAD_OFF_SP, 8'h00);
		stop_test();
	end

	// generous bound: the tests take a few hundred cycles
	initial
	begin
		repeat (20000) @(posedge clock_i);
		miscompares++;
		stop_test();
	end
endmodule
`default_nettype wire
